/* inc/crc_pkg.sv */
// Purpose: shared constants and types for the changeover remote port
// Assumes: 100 MHz pclk
// Notes: register map and event bits
package crc_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned DEBOUNCE_US = 5;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_EVT = 12'h008;
  localparam logic [11:0] ADDR_EVT_CLR = 12'h00C;
  localparam logic [11:0] ADDR_EVT_EN = 12'h010;
  localparam logic [2:0] CTRL_RESET = 3'h1;
  localparam logic [2:0] EVT_RESET = 3'h0;
  localparam logic [2:0] EN_RESET = 3'h0;
  localparam int unsigned NUM_EVT = 3;
  typedef enum logic [1:0] {
    CRC_MAIN = 2'b00,
    CRC_SPARE = 2'b01
  } crc_src_e;
  typedef struct packed {
    logic override_n;
    logic select_n;
    logic reset_n;
  } crc_remote_s;
  typedef struct packed {
    logic fault_latch;
    logic switched;
    logic new_fault;
  } crc_evt_s;
endpackage

/* rtl/crc_remote_port.sv */
// Purpose: remote-control port of a reference changeover unit
// Assumes: remote pins asynchronous inputs, synchronised and debounced here
// Notes: APB registers for panel setting, status and events
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
module crc_remote_port #(
  parameter int unsigned DEB_CYC = crc_pkg::DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fault detector inputs
  input wire logic fault_main,
  input wire logic fault_spare,
  // remote connector inputs, active low
  input wire crc_pkg::crc_remote_s remote,
  // remote connector outputs
  output logic main_reference,
  output logic spare_reference,
  output logic latched_fault_flag,
  output logic isolated_fault_contact_pos,
  output logic isolated_fault_contact_neg,
  // interrupt
  output logic irq
);
  localparam int CW = $clog2(DEB_CYC + 1);

  // two-flop synchronisers for the three remote lines
  crc_pkg::crc_remote_s sync1;
  crc_pkg::crc_remote_s sync2;
  crc_pkg::crc_remote_s stable;
  logic [2:0] deb_cnt_hit;
  logic [CW-1:0] deb_cnt [3];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
    end
    else
    begin
      sync1 <= remote;
      sync2 <= sync1;
    end
  end

  // debounce: a new level must hold DEB_CYC + 1 cycles
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_deb
      assign deb_cnt_hit[gi] = (deb_cnt[gi] == CW'(DEB_CYC));
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          deb_cnt[gi] <= '0;
          stable[gi] <= 1'b1;
        end
        else if (sync2[gi] == stable[gi])
          deb_cnt[gi] <= '0;
        else if (deb_cnt_hit[gi])
        begin
          stable[gi] <= sync2[gi];
          deb_cnt[gi] <= '0;
        end
        else
          deb_cnt[gi] <= deb_cnt[gi] + CW'(1);
      end
    end
  endgenerate

  logic select_prev;
  logic reset_prev;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      select_prev <= 1'b1;
      reset_prev <= 1'b1;
    end
    else
    begin
      select_prev <= stable.select_n;
      reset_prev <= stable.reset_n;
    end
  end

  // registers
  logic [2:0] ctrl;
  crc_pkg::crc_evt_s evt;
  crc_pkg::crc_evt_s evt_en;
  crc_pkg::crc_src_e src;
  logic fault_latch;

  wire panel_auto = ctrl[0];
  wire sw_toggle = ctrl[1];
  wire sw_fault_reset = ctrl[2];
  wire auto_on = panel_auto & stable.override_n;
  wire select_fall = select_prev & ~stable.select_n;
  wire reset_req = (reset_prev & ~stable.reset_n) | sw_fault_reset;
  wire fault_now = fault_main | fault_spare;
  wire sel_fault = (src == crc_pkg::CRC_MAIN) ? fault_main : fault_spare;
  wire other_fault = (src == crc_pkg::CRC_MAIN) ? fault_spare : fault_main;
  wire auto_move = auto_on & sel_fault & ~other_fault;
  wire do_toggle = select_fall | sw_toggle | auto_move;

  wire wr = psel & penable & pwrite;
  wire wr_ctrl = wr & (paddr == crc_pkg::ADDR_CTRL);
  wire wr_clr = wr & (paddr == crc_pkg::ADDR_EVT_CLR);
  wire wr_en = wr & (paddr == crc_pkg::ADDR_EVT_EN);
  wire mapped = (paddr == crc_pkg::ADDR_CTRL) |
                (paddr == crc_pkg::ADDR_STATUS) |
                (paddr == crc_pkg::ADDR_EVT) |
                (paddr == crc_pkg::ADDR_EVT_CLR) |
                (paddr == crc_pkg::ADDR_EVT_EN);

  crc_pkg::crc_src_e next_src;
  assign next_src = do_toggle ?
    ((src == crc_pkg::CRC_MAIN) ? crc_pkg::CRC_SPARE : crc_pkg::CRC_MAIN)
    : src;

  logic next_fault_latch;
  // persisting fault re-sets immediately
  assign next_fault_latch = fault_now | (fault_latch & ~reset_req);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src <= crc_pkg::CRC_MAIN;
      fault_latch <= 1'b0;
    end
    else
    begin
      src <= next_src;
      fault_latch <= next_fault_latch;
    end
  end

  // control: bit0 panel auto, bit1/2 self-clearing strobes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= crc_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= pwdata[2:0];
    else
      ctrl <= {1'b0, 1'b0, ctrl[0]};
  end

  crc_pkg::crc_evt_s evt_set;
  assign evt_set.fault_latch = next_fault_latch & ~fault_latch;
  assign evt_set.switched = do_toggle;
  assign evt_set.new_fault = fault_now;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt <= crc_pkg::EVT_RESET;
      evt_en <= crc_pkg::EN_RESET;
    end
    else
    begin
      // set wins over clear
      evt <= evt_set | (evt & ~(wr_clr ? pwdata[2:0] : 3'h0));
      if (wr_en)
        evt_en <= pwdata[2:0];
    end
  end

  wire [31:0] status_word = {26'h0, auto_on, fault_now, fault_main,
                             fault_spare, fault_latch,
                             src == crc_pkg::CRC_SPARE};
  wire [31:0] rd_mux =
    (paddr == crc_pkg::ADDR_CTRL) ? {29'h0, ctrl} :
    (paddr == crc_pkg::ADDR_STATUS) ? status_word :
    (paddr == crc_pkg::ADDR_EVT) ? {29'h0, evt} :
    (paddr == crc_pkg::ADDR_EVT_EN) ? {29'h0, evt_en} : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      main_reference <= 1'b1;
      spare_reference <= 1'b0;
      latched_fault_flag <= 1'b0;
      isolated_fault_contact_pos <= 1'b0;
    end
    else
    begin
      prdata <= (psel & ~penable & ~pwrite) ? rd_mux : prdata;
      main_reference <= (next_src == crc_pkg::CRC_MAIN);
      spare_reference <= (next_src == crc_pkg::CRC_SPARE);
      latched_fault_flag <= next_fault_latch;
      isolated_fault_contact_pos <= next_fault_latch;
    end
  end

  // negative side of the contact pair is the return leg
  assign isolated_fault_contact_neg = 1'b0;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign irq = |(evt & evt_en);

  // assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // select edge with no competing toggle source
  sequence s_select_edge;
    select_fall && !sw_toggle && !auto_move;
  endsequence
  // select still low after its edge was taken
  sequence s_select_held;
    !select_prev && !stable.select_n && !sw_toggle && !auto_move;
  endsequence
  // selected source failed, other still good
  sequence s_auto_fault;
    auto_on && sel_fault && !other_fault && !select_fall && !sw_toggle;
  endsequence

  a_src_outputs: assert property (
    main_reference == ~spare_reference)
    else $error("source outputs not exclusive");
  a_main_level: assert property (
    main_reference == (src == crc_pkg::CRC_MAIN))
    else $error("main output mismatch");
  a_spare_level: assert property (
    spare_reference == (src == crc_pkg::CRC_SPARE))
    else $error("spare output mismatch");
  a_fault_sets: assert property (
    fault_now |=> latched_fault_flag)
    else $error("fault did not set flag");
  a_flag_holds: assert property (
    latched_fault_flag && !reset_req |=> latched_fault_flag)
    else $error("flag dropped without reset");
  a_reset_clears: assert property (
    reset_req && !fault_now |=> !latched_fault_flag)
    else $error("reset did not clear flag");
  a_remote_reset: assert property (
    $fell(stable.reset_n) && !fault_now |=> !latched_fault_flag)
    else $error("remote reset did not clear flag");
  a_contact_flag: assert property (
    isolated_fault_contact_pos == latched_fault_flag)
    else $error("contact disagrees with flag");
  a_select_toggle: assert property (
    s_select_edge |=> main_reference != $past(main_reference))
    else $error("select did not toggle");
  a_src_steady: assert property (
    !select_fall && !sw_toggle && !auto_move |=> $stable(src))
    else $error("source moved without cause");
  a_select_once: assert property (
    s_select_held |=> $stable(src))
    else $error("held select toggled again");
  a_override_off: assert property (
    !stable.override_n |-> !auto_on)
    else $error("override ignored");
  a_panel_off: assert property (
    !panel_auto |-> !auto_move)
    else $error("auto move with panel off");
  a_panel_ignores: assert property (
    !panel_auto |-> !auto_on)
    else $error("override acted with panel off");
  a_auto_move: assert property (
    s_auto_fault |=> main_reference != $past(main_reference))
    else $error("no failover");
  a_fault_persist: assert property (
    reset_req && fault_now |=> latched_fault_flag)
    else $error("persisting fault cleared");
  a_deb_hold: assert property (
    $fell(stable.select_n) |-> $past(sync2.select_n) == 1'b0)
    else $error("select changed without debounce");
  a_evt_set_wins: assert property (
    wr_clr && fault_now |=> evt.new_fault)
    else $error("clear beat a fault event");
endmodule // crc_remote_port

/* sim/crc_remote_model.sv */
// Purpose: remote switches wired to the changeover connector
// Assumes: pull-ups on each line, switch closed pulls it low
// Notes: bit 2 override, bit 1 select, bit 0 fault reset
`timescale 1ns/1ps
module crc_remote_model (
  // clock
  input wire logic pclk,
  // connector lines
  output crc_pkg::crc_remote_s remote
);
  logic [2:0] closed = 3'h0;

  // open switch reads high through its pull-up
  assign remote = crc_pkg::crc_remote_s'(~closed);

  task automatic hold(input int i, input logic on);
    closed[i] <= on;
  endtask

  task automatic press(input int i, input int n);
    closed[i] <= 1'b1;
    repeat (n) @(posedge pclk);
    closed[i] <= 1'b0;
  endtask
endmodule // crc_remote_model

/* sim/crc_remote_port_tb.sv */
// Purpose: self-checking bench for the changeover remote port
// Assumes: short debounce parameter, remote switches modelled
// Notes: APB master tasks, one task per scenario
`timescale 1ns/1ps
module crc_remote_port_tb;
  localparam int D = 3;
  localparam int W = D + 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fault_main = 1'b0;
  logic fault_spare = 1'b0;
  crc_pkg::crc_remote_s remote;
  logic main_ref, spare_ref, flag, c_pos, c_neg, irq;
  logic [31:0] r;
  logic e;
  int fail_count = 0;
  int check_count = 0;

  crc_remote_port #(.DEB_CYC(D)) crc_remote_port_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fault_main(fault_main),
    .fault_spare(fault_spare), .remote(remote),
    .main_reference(main_ref), .spare_reference(spare_ref),
    .latched_fault_flag(flag), .isolated_fault_contact_pos(c_pos),
    .isolated_fault_contact_neg(c_neg), .irq(irq));
  crc_remote_model crc_remote_model_inst (.pclk(pclk), .remote(remote));

  initial
  begin
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge: next call never re-drives psel in this step
    @(posedge pclk);
  endtask

  task automatic clear_fault();
    crc_remote_model_inst.press(0, W);
    cyc(W);
  endtask

  task automatic t_reset();
    chk(main_ref, 1);
    chk(spare_ref, 0);
    chk({flag, c_pos, c_neg, irq}, 0);
    apb(1'b0, crc_pkg::ADDR_CTRL, 32'h0);
    chk(r, 32'h1);
  endtask

  task automatic t_select();
    crc_remote_model_inst.hold(1, 1'b1);
    cyc(W);
    chk({main_ref, spare_ref}, 2'b01);
    cyc(W);
    chk({main_ref, spare_ref}, 2'b01);
    crc_remote_model_inst.hold(1, 1'b0);
    cyc(W);
    crc_remote_model_inst.press(1, W);
    cyc(W);
    chk({main_ref, spare_ref}, 2'b10);
  endtask

  task automatic t_fault();
    fault_main <= 1'b1;
    cyc(3);
    chk({flag, c_pos}, 2'b11);
    chk(spare_ref, 1);
    apb(1'b0, crc_pkg::ADDR_STATUS, 32'h0);
    chk(r, 32'h3B);
    fault_main <= 1'b0;
    cyc(3);
    chk({flag, c_pos}, 2'b11);
    clear_fault();
    chk({flag, c_pos}, 2'b00);
    fault_main <= 1'b1;
    clear_fault();
    chk({flag, spare_ref}, 2'b11);
    fault_main <= 1'b0;
    clear_fault();
  endtask

  task automatic t_override();
    crc_remote_model_inst.hold(2, 1'b1);
    cyc(W);
    fault_spare <= 1'b1;
    cyc(3);
    chk(spare_ref, 1);
    fault_spare <= 1'b0;
    crc_remote_model_inst.hold(2, 1'b0);
    cyc(W);
    clear_fault();
    fault_spare <= 1'b1;
    cyc(3);
    chk(main_ref, 1);
    fault_spare <= 1'b0;
    clear_fault();
  endtask

  task automatic t_panel_off();
    apb(1'b1, crc_pkg::ADDR_CTRL, 32'h0);
    fault_main <= 1'b1;
    cyc(3);
    chk({main_ref, flag}, 2'b11);
    fault_main <= 1'b0;
    clear_fault();
    apb(1'b1, crc_pkg::ADDR_CTRL, 32'h1);
  endtask

  task automatic t_irq();
    apb(1'b0, 12'h014, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    apb(1'b1, crc_pkg::ADDR_EVT_CLR, 32'h7);
    apb(1'b1, crc_pkg::ADDR_EVT_EN, 32'h1);
    chk(irq, 0);
    fault_spare <= 1'b1;
    cyc(3);
    fault_spare <= 1'b0;
    cyc(3);
    chk(irq, 1);
    apb(1'b1, crc_pkg::ADDR_EVT_EN, 32'h0);
    chk(irq, 0);
    apb(1'b1, crc_pkg::ADDR_EVT_CLR, 32'h7);
    apb(1'b0, crc_pkg::ADDR_EVT, 32'h0);
    chk(r, 32'h0);
    apb(1'b1, crc_pkg::ADDR_EVT_EN, 32'h7);
    chk(irq, 0);
    apb(1'b1, crc_pkg::ADDR_CTRL, 32'h5);
    cyc(1);
    chk(flag, 0);
    apb(1'b1, crc_pkg::ADDR_CTRL, 32'h3);
    cyc(1);
    chk({main_ref, spare_ref}, 2'b01);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    cyc(20000);
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    cyc(5);
    presetn <= 1'b1;
    cyc(1);
    t_reset();
    t_select();
    t_fault();
    t_override();
    t_panel_off();
    t_irq();
    report_and_stop();
  end
endmodule // crc_remote_port_tb
